// ===== verilog/pmc_power_csr.sv
// power-management control/status and bridge extension config registers
// Operation
// RULE1 - flag sets on wake event, ignoring enable
// RULE2 - write one clears flag; zero ignored
// RULE3 - sticky when D3cold wake supported, else zero
// RULE4 - enable bit gates the wake request
// RULE5 - software clears sticky enable at load
// RULE6 - data scale read-only, reads 00b
// RULE7 - data select reads zero without data
// RULE8 - power state codes D0 D1 D2 D3hot
// RULE9 - unsupported state writes are dropped
// RULE10 - software writes reserved bits as zero
// RULE11 - registers at pointer plus 4h, 6h
// RULE12 - bridge extension byte read-only zero
// RULE13 - support mask D3cold bit selects stickiness
// RULE14 - sticky bits survive pci reset only
// RULE15 - request only when flag and enable
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_power_csr #(
   parameter logic [7:0] CAP_BASE    = `PMC_CAP_BASE_DEF,
   parameter logic [4:0] WAKE_SUPPORT = `PMC_SUPPORT_DEF,
   parameter logic       D1_SUPPORT  = 1'b1,
   parameter logic       D2_SUPPORT  = 1'b1
) (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        auxReset,
   input  wire logic        wakeSource,
   input  wire logic        cfgRead,
   input  wire logic        cfgWrite,
   input  wire logic [7:0]  cfgAddr,
   input  wire logic [3:0]  cfgByteEn,
   input  wire logic [31:0] cfgWrData,
   output logic [31:0]      cfgRdData,
   output logic             cfgHit,
   output logic [1:0]       powerState,
   output logic             wakeRequest
);
   typedef struct packed {
      pmc_pkg::pmc_pstate_e ps;
      logic [31:0]          rdData;
      logic                 hit;
      logic                 req;
   } pmc_csr_s;

   pmc_csr_s r_ff;
   pmc_csr_s nxt_r;

   logic       stickyMode;
   logic       wakeEvent;
   logic       wakeFlag;
   logic       wakeEnable;
   logic       csrHit;
   logic       flagClear;
   logic       enableWrite;
   logic       stateOk;
   logic [1:0] newPs;
   logic [15:0] csrView;
   logic [7:0]  bseView;

   // D3cold support bit decides stickiness
   assign stickyMode = WAKE_SUPPORT[`PMC_SUPPORT_D3COLD]; // RULE13 RULE3

   // dword at base+4 holds csr low half and bridge byte
   assign csrHit = (cfgAddr[7:2] == CAP_BASE[7:2] + 6'(`PMC_CSR_OFFSET >> 2)); // RULE11

   assign flagClear   = cfgWrite && csrHit && cfgByteEn[1]
                        && cfgWrData[`PMC_BIT_FLAG]; // RULE2
   assign enableWrite = cfgWrite && csrHit && cfgByteEn[1];
   assign newPs       = cfgWrData[`PMC_BIT_PS_HI:`PMC_BIT_PS_LO];

   // only mandatory or supported optional states accepted
   always_comb begin
      case (newPs)
         2'h1:    stateOk = D1_SUPPORT;
         2'h2:    stateOk = D2_SUPPORT;
         default: stateOk = 1'b1;
      endcase
   end

   pmc_event_sync u_sync (
      .core_clk  (core_clk),
      .reset     (reset),
      .rawIn     (wakeSource),
      .risePulse (wakeEvent)
   );

   pmc_sticky_wake u_sticky (
      .core_clk    (core_clk),
      .auxReset    (auxReset),
      .pciReset    (reset),
      .stickyMode  (stickyMode),
      .wakeEvent   (wakeEvent),
      .flagClear   (flagClear),
      .enableWrite (enableWrite),
      .enableData  (cfgWrData[`PMC_BIT_ENABLE]),
      .wakeFlag    (wakeFlag),
      .wakeEnable  (wakeEnable)
   );

   // read view; scale and select read zero, reserved zero
   always_comb begin
      csrView = 16'h0000;
      csrView[`PMC_BIT_FLAG] = wakeFlag;
      csrView[`PMC_BIT_SCALE_HI:`PMC_BIT_SCALE_LO] = `PMC_SCALE_NONE; // RULE6
      csrView[`PMC_BIT_SEL_HI:`PMC_BIT_SEL_LO] = `PMC_SEL_RESET;      // RULE7
      csrView[`PMC_BIT_ENABLE] = wakeEnable;
      csrView[`PMC_BIT_PS_HI:`PMC_BIT_PS_LO] = r_ff.ps;               // RULE8
      bseView = `PMC_BSE_RESET;                                       // RULE12
   end

   // next state of power field, read data and request
   always_comb begin
      nxt_r        = r_ff;
      nxt_r.hit    = (cfgRead || cfgWrite) && csrHit;
      nxt_r.rdData = 32'h0000_0000;
      if (cfgRead && csrHit) begin
         nxt_r.rdData = {8'h00, bseView, csrView}; // RULE11
      end
      if (cfgWrite && csrHit && cfgByteEn[0] && stateOk) begin
         nxt_r.ps = pmc_pkg::pmc_pstate_e'(newPs); // RULE8 RULE9
      end
      nxt_r.req = wakeFlag && wakeEnable; // RULE15 RULE4
      if (flagClear) begin
         nxt_r.req = 1'b0; // RULE2
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         r_ff <= '{ps: pmc_pkg::PMC_D0, rdData: 32'h0000_0000, hit: 1'b0, req: 1'b0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign cfgRdData   = r_ff.rdData;
   assign cfgHit      = r_ff.hit;
   assign powerState  = r_ff.ps;
   assign wakeRequest = r_ff.req;

   // bus request shapes used by the checks below
   sequence s_csr_read;
      cfgRead && csrHit;
   endsequence

   sequence s_csr_write;
      cfgWrite && csrHit;
   endsequence

   sequence s_miss_access;
      (cfgRead || cfgWrite) && !csrHit;
   endsequence

   sequence s_bus_idle;
      !cfgRead && !cfgWrite;
   endsequence

   sequence s_ps_write;
      cfgWrite && csrHit && cfgByteEn[0];
   endsequence

   sequence s_enable_write;
      cfgWrite && csrHit && cfgByteEn[1];
   endsequence

   sequence s_flag_clear_write;
      flagClear;
   endsequence

   // wake request against flag and enable
   a_req_needs_enable: assert property (@(posedge core_clk) // RULE4 RULE15
      disable iff (reset)
      wakeRequest |-> $past(wakeEnable) && $past(wakeFlag))
      else $error("request without flag and enable");
   a_req_follows_both: assert property (@(posedge core_clk) // RULE15
      disable iff (reset)
      wakeFlag && wakeEnable && !flagClear |=> wakeRequest)
      else $error("request not raised");
   a_req_off_no_en: assert property (@(posedge core_clk) // RULE4
      disable iff (reset)
      !wakeEnable |=> !wakeRequest)
      else $error("request while enable low");
   a_req_off_no_flag: assert property (@(posedge core_clk) // RULE15
      disable iff (reset)
      !wakeFlag |=> !wakeRequest)
      else $error("request while flag low");
   a_clear_drops_req: assert property (@(posedge core_clk) // RULE2
      disable iff (reset)
      s_flag_clear_write |=> !wakeRequest)
      else $error("request after clear");

   // wake flag and enable bit
   a_flag_by_event: assert property (@(posedge core_clk) // RULE1
      disable iff (reset || auxReset)
      wakeEvent && !wakeEnable |=> wakeFlag)
      else $error("flag not set with enable low");
   a_set_wins: assert property (@(posedge core_clk) // RULE1
      disable iff (reset || auxReset)
      s_flag_clear_write ##0 wakeEvent |=> wakeFlag)
      else $error("clear beat a wake event");
   a_flag_zero_write: assert property (@(posedge core_clk) // RULE2
      disable iff (reset || auxReset)
      s_csr_write ##0 !cfgWrData[`PMC_BIT_FLAG] && !wakeEvent |=> $stable(wakeFlag))
      else $error("flag changed by zero write");
   a_enable_written: assert property (@(posedge core_clk) // RULE4
      disable iff (reset || auxReset)
      s_enable_write |=> wakeEnable == $past(cfgWrData[`PMC_BIT_ENABLE]))
      else $error("enable write lost");
   a_enable_kept: assert property (@(posedge core_clk) // RULE4
      disable iff (reset || auxReset)
      !enableWrite |=> $stable(wakeEnable))
      else $error("enable changed without write");
   a_plain_reset_clear: assert property (@(posedge core_clk) // RULE3
      reset && !stickyMode |=> !wakeFlag && !wakeEnable)
      else $error("plain wake bits kept over reset");
   a_aux_reset_clear: assert property (@(posedge core_clk) // RULE14
      auxReset |=> !wakeFlag && !wakeEnable)
      else $error("wake bits kept over aux reset");

   // read view of the register dword
   a_scale_select_zero: assert property (@(posedge core_clk) // RULE6 RULE7
      disable iff (reset)
      s_csr_read |=> cfgRdData[`PMC_BIT_SCALE_HI:`PMC_BIT_SEL_LO] == 6'h00)
      else $error("scale or select nonzero");
   a_bse_reads_zero: assert property (@(posedge core_clk) // RULE12
      disable iff (reset)
      s_csr_read |=> cfgRdData[23:16] == 8'h00)
      else $error("bridge byte nonzero");
   a_bse_top_bits: assert property (@(posedge core_clk) // RULE12
      disable iff (reset)
      s_csr_read |=> !cfgRdData[16 + `PMC_BIT_BPCC] && !cfgRdData[16 + `PMC_BIT_D3ACT])
      else $error("bridge control bits set");
   a_rd_upper_zero: assert property (@(posedge core_clk) // RULE11
      disable iff (reset)
      s_csr_read |=> cfgRdData[31:24] == 8'h00)
      else $error("top byte nonzero");
   a_rd_reserved_zero: assert property (@(posedge core_clk) // RULE11
      disable iff (reset)
      s_csr_read |=> cfgRdData[7:2] == 6'h00)
      else $error("reserved bits nonzero");
   a_rd_flag_view: assert property (@(posedge core_clk) // RULE1
      disable iff (reset)
      s_csr_read |=> cfgRdData[`PMC_BIT_FLAG] == $past(wakeFlag))
      else $error("flag readback wrong");
   a_rd_enable_view: assert property (@(posedge core_clk) // RULE4
      disable iff (reset)
      s_csr_read |=> cfgRdData[`PMC_BIT_ENABLE] == $past(wakeEnable))
      else $error("enable readback wrong");
   a_ps_readback: assert property (@(posedge core_clk) // RULE8 RULE11
      disable iff (reset)
      s_csr_read |=> cfgRdData[1:0] == powerState && cfgHit)
      else $error("state readback wrong");

   // decode and answer timing
   a_hit_on_write: assert property (@(posedge core_clk) // RULE11
      disable iff (reset)
      s_csr_write |=> cfgHit)
      else $error("write not answered");
   a_no_hit_miss: assert property (@(posedge core_clk) // RULE11
      disable iff (reset)
      s_miss_access |=> !cfgHit)
      else $error("hit on foreign address");
   a_miss_reads_zero: assert property (@(posedge core_clk) // RULE11
      disable iff (reset)
      s_miss_access |=> cfgRdData == 32'h0000_0000)
      else $error("data on foreign address");
   a_hit_idle: assert property (@(posedge core_clk) // RULE11
      disable iff (reset)
      s_bus_idle |=> !cfgHit)
      else $error("hit without request");
   a_rd_idle_zero: assert property (@(posedge core_clk) // RULE11
      disable iff (reset)
      !cfgRead |=> cfgRdData == 32'h0000_0000)
      else $error("read data without read");
   a_ps_reset_d0: assert property (@(posedge core_clk) // RULE8
      reset |=> powerState == 2'h0 && !wakeRequest && !cfgHit && cfgRdData == 32'h0)
      else $error("outputs not cleared by reset");

   // power state field
   a_ps_write_taken: assert property (@(posedge core_clk) // RULE8
      disable iff (reset)
      s_ps_write ##0 stateOk |=> powerState == $past(newPs))
      else $error("state write lost");
   a_d0_taken: assert property (@(posedge core_clk) // RULE8
      disable iff (reset)
      s_ps_write ##0 newPs == 2'h0 |=> powerState == 2'h0)
      else $error("D0 write lost");
   a_d3_taken: assert property (@(posedge core_clk) // RULE8
      disable iff (reset)
      s_ps_write ##0 newPs == 2'h3 |=> powerState == 2'h3)
      else $error("D3hot write lost");
   a_bad_ps_dropped: assert property (@(posedge core_clk) // RULE9
      disable iff (reset)
      s_csr_write ##0 !stateOk |=> $stable(powerState))
      else $error("unsupported state accepted");
   a_d1_dropped: assert property (@(posedge core_clk) // RULE9
      disable iff (reset)
      s_ps_write ##0 newPs == 2'h1 && !D1_SUPPORT |=> $stable(powerState))
      else $error("unsupported D1 accepted");
   a_d2_dropped: assert property (@(posedge core_clk) // RULE9
      disable iff (reset)
      s_ps_write ##0 newPs == 2'h2 && !D2_SUPPORT |=> $stable(powerState))
      else $error("unsupported D2 accepted");
   a_ps_no_be: assert property (@(posedge core_clk) // RULE8
      disable iff (reset)
      s_csr_write ##0 !cfgByteEn[0] |=> $stable(powerState))
      else $error("state written without byte enable");
   a_read_no_side: assert property (@(posedge core_clk) // RULE8
      disable iff (reset)
      s_csr_read ##0 !cfgWrite |=> $stable(powerState))
      else $error("state changed by read");
endmodule : pmc_power_csr
`default_nettype wire

// ===== verilog/pmc_consts.svh
// offsets, field positions and reset values of the power-management registers
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_CAP_PTR_ADDR      8'h34
`define PMC_CSR_OFFSET        8'h04
`define PMC_BSE_OFFSET        8'h06
`define PMC_CAP_BASE_DEF      8'h40
`define PMC_BIT_FLAG          15
`define PMC_BIT_SCALE_HI      14
`define PMC_BIT_SCALE_LO      13
`define PMC_BIT_SEL_HI        12
`define PMC_BIT_SEL_LO        9
`define PMC_BIT_ENABLE        8
`define PMC_BIT_PS_HI         1
`define PMC_BIT_PS_LO         0
`define PMC_BIT_BPCC          7
`define PMC_BIT_D3ACT         6
`define PMC_SEL_RESET         4'h0
`define PMC_SCALE_NONE        2'h0
`define PMC_BSE_RESET         8'h00
`define PMC_SUPPORT_DEF       5'h19
`define PMC_SUPPORT_D3COLD    4
`endif

// ===== verilog/pmc_pkg.sv
// types shared by the power-management register logic
package pmc_pkg;
   typedef enum logic [1:0] {
      PMC_D0    = 2'h0,
      PMC_D1    = 2'h1,
      PMC_D2    = 2'h2,
      PMC_D3HOT = 2'h3
   } pmc_pstate_e;
endpackage : pmc_pkg

// ===== verilog/pmc_sticky_wake.sv
// sticky wake flag and enable kept on auxiliary power
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_sticky_wake (
   input  wire logic core_clk,
   input  wire logic auxReset,
   input  wire logic pciReset,
   input  wire logic stickyMode,
   input  wire logic wakeEvent,
   input  wire logic flagClear,
   input  wire logic enableWrite,
   input  wire logic enableData,
   output logic      wakeFlag,
   output logic      wakeEnable
);
   typedef struct packed {
      logic flag;
      logic enable;
   } pmc_sticky_s;

   pmc_sticky_s st_ff;
   pmc_sticky_s nxt_st;

   // event set wins over write-one clear
   always_comb begin
      nxt_st = st_ff;
      if (flagClear) begin
         nxt_st.flag = 1'b0;          // RULE2
      end
      if (wakeEvent) begin
         nxt_st.flag = 1'b1;          // RULE1
      end
      if (enableWrite) begin
         nxt_st.enable = enableData;  // RULE4
      end
   end

   // aux reset clears always; pci reset only when not sticky
   always_ff @(posedge core_clk) begin
      if (auxReset || (pciReset && !stickyMode)) begin
         st_ff <= '0;                 // RULE3 RULE14
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wakeFlag   = st_ff.flag;
   assign wakeEnable = st_ff.enable;

   a_flag_set_event: assert property (@(posedge core_clk) // RULE1
      disable iff (auxReset || pciReset)
      wakeEvent |=> wakeFlag)
      else $error("wake flag missed event");
   a_flag_clear_one: assert property (@(posedge core_clk) // RULE2
      disable iff (auxReset || pciReset)
      flagClear && !wakeEvent |=> !wakeFlag)
      else $error("flag not cleared");
   a_sticky_keep: assert property (@(posedge core_clk) // RULE14
      disable iff (auxReset)
      pciReset && stickyMode |=> $stable(wakeFlag) && $stable(wakeEnable))
      else $error("sticky bits lost on pci reset");
endmodule : pmc_sticky_wake
`default_nettype wire

// ===== verilog/pmc_event_sync.sv
// two-flop synchroniser and rising-edge pulse for the wake source
`timescale 1ns/1ps
`default_nettype none
module pmc_event_sync (
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic rawIn,
   output logic      risePulse
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } pmc_sync_s;

   pmc_sync_s sy_ff;
   pmc_sync_s nxt_sy;

   // shift chain; first stage feeds only second
   always_comb begin
      nxt_sy    = sy_ff;
      nxt_sy.s1 = rawIn;
      nxt_sy.s2 = sy_ff.s1;
      nxt_sy.s3 = sy_ff.s2;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sy_ff <= '0;
      end else begin
         sy_ff <= nxt_sy;
      end
   end

   assign risePulse = sy_ff.s2 && !sy_ff.s3;
endmodule : pmc_event_sync
`default_nettype wire

// ===== verification/pmc_host_model.sv
// host bridge and driver software issuing configuration cycles
`timescale 1ns/1ps
`default_nettype none
module pmc_host_model (
   input  wire logic        core_clk,
   output logic             cfgRead,
   output logic             cfgWrite,
   output logic [7:0]       cfgAddr,
   output logic [3:0]       cfgByteEn,
   output logic [31:0]      cfgWrData,
   input  wire logic [31:0] cfgRdData,
   input  wire logic        cfgHit
);
   // idle bus at time zero
   initial begin
      cfgRead = 1'b0;
      cfgWrite = 1'b0;
      cfgAddr = 8'h00;
      cfgByteEn = 4'h0;
      cfgWrData = 32'h0;
   end
   // one-cycle request, answer taken one cycle later
   task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                         output logic [31:0] rd, output logic hit);
      @(negedge core_clk);
      cfgWrite = wr;
      cfgRead = ~wr;
      cfgAddr = a;
      cfgByteEn = 4'hf;
      cfgWrData = {16'hffff, d & 16'hff03};
      @(negedge core_clk);
      rd = cfgRdData;
      hit = cfgHit;
      cfgWrite = 1'b0;
      cfgRead = 1'b0;
      cfgAddr = ~cfgAddr;     // released bus shows no stale value
      cfgWrData = ~cfgWrData;
   endtask : access
   // driver load clears the sticky enable
   task automatic load_driver(output logic [31:0] rd, output logic hit);
      access(1'b1, 8'h44, 16'h0000, rd, hit);
   endtask : load_driver
endmodule : pmc_host_model
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the power-management registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        core_clk;
   logic        reset;
   logic        auxReset;
   logic        wakeSource;
   logic        cfgRead;
   logic        cfgWrite;
   logic [7:0]  cfgAddr;
   logic [3:0]  cfgByteEn;
   logic [31:0] cfgWrData;
   logic [31:0] cfgRdData;
   logic        cfgHit;
   logic [1:0]  powerState;
   logic        wakeRequest;
   logic [31:0] rdPlain;
   logic        reqPlain;
   logic [31:0] rd;
   logic        hit;
   logic [15:0] req;
   logic [1:0]  ps;
   logic        en;
   int          seed;
   int          nErrors;
   int          checked;

   pmc_power_csr #(.D2_SUPPORT(1'b0)) u_pmc_power_csr (
      .core_clk(core_clk), .reset(reset), .auxReset(auxReset), .wakeSource(wakeSource),
      .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
      .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgHit(cfgHit),
      .powerState(powerState), .wakeRequest(wakeRequest));
   // twin without D3cold wake support: flag and enable not sticky
   pmc_power_csr #(.WAKE_SUPPORT(5'h09), .D2_SUPPORT(1'b0)) u_pmc_power_csr_plain (
      .core_clk(core_clk), .reset(reset), .auxReset(auxReset), .wakeSource(wakeSource),
      .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
      .cfgWrData(cfgWrData), .cfgRdData(rdPlain), .cfgHit(),
      .powerState(), .wakeRequest(reqPlain));
   pmc_host_model u_pmc_host_model (
      .core_clk(core_clk), .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
      .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgHit(cfgHit));

   // 100 MHz clock
   always #5 core_clk = ~core_clk;

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         nErrors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic rw(input logic wr, input logic [7:0] a, input logic [15:0] d);
      u_pmc_host_model.access(wr, a, d, rd, hit);
   endtask : rw
   function automatic logic [31:0] exp_csr(input logic f, input logic e, input logic [1:0] p);
      return {16'h0000, f, 6'h00, e, 6'h00, p};
   endfunction : exp_csr
   // unsupported state keeps the old one
   function automatic logic [1:0] nxt_ps(input logic [1:0] cur, input logic [1:0] r);
      return (r == pmc_pkg::PMC_D2) ? cur : r;
   endfunction : nxt_ps
   task automatic end_sim;
      $display("checks %0d errors %0d", checked, nErrors);
      if (nErrors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   // hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      nErrors++;
      end_sim();
   end

   // main sequence
   initial begin
      seed = 30022;
      core_clk = 1'b0;
      reset = 1'b1;
      auxReset = 1'b1;
      wakeSource = 1'b0;
      nErrors = 0;
      checked = 0;
      ps = 2'h0;
      repeat (5) @(negedge core_clk);
      reset = 1'b0;
      auxReset = 1'b0;
      rw(1'b0, 8'h46, 16'h0);
      chk("hit", {31'h0, hit}, 32'h1);
      chk("csr reset", rd, exp_csr(1'b0, 1'b0, 2'h0));
      rw(1'b0, 8'h48, 16'h0);
      chk("unmapped hit", {31'h0, hit}, 32'h0);
      chk("unmapped data", rd, 32'h0);
      u_pmc_host_model.load_driver(rd, hit);
      // corner state codes first, then random writes
      for (int i = 0; i < 24; i++) begin
         req = (i < 4) ? 16'(i) : 16'($random(seed));
         req[15] = 1'b0;
         rw(1'b1, 8'h44, req);
         ps = nxt_ps(ps, req[1:0]);
         en = req[8];
         chk("state", {30'h0, powerState}, {30'h0, ps});
         rw(1'b0, 8'h44, 16'h0);
         chk("csr", rd, exp_csr(1'b0, en, ps));
      end
      // wake event with enable off
      rw(1'b1, 8'h44, {14'h0, ps});
      wakeSource = 1'b1;
      repeat (6) @(negedge core_clk);
      chk("request off", {31'h0, wakeRequest}, 32'h0);
      rw(1'b1, 8'h44, 16'h0100 | {14'h0, ps});
      @(negedge core_clk);
      chk("request on", {31'h0, wakeRequest}, 32'h1);
      rw(1'b0, 8'h44, 16'h0);
      chk("flag set", rd, exp_csr(1'b1, 1'b1, ps));
      chk("plain flag set", rdPlain, exp_csr(1'b1, 1'b1, ps));
      // source drops on the same edge as reset so no stale level looks like a new edge after release
      wakeSource = 1'b0;
      reset = 1'b1;
      @(negedge core_clk);
      reset = 1'b0;
      rw(1'b0, 8'h44, 16'h0);
      chk("sticky", rd, exp_csr(1'b1, 1'b1, 2'h0));
      chk("plain reset", rdPlain, exp_csr(1'b0, 1'b0, 2'h0));
      chk("plain request", {31'h0, reqPlain}, 32'h0);
      rw(1'b1, 8'h44, 16'h8100);
      @(negedge core_clk);
      chk("cleared request", {31'h0, wakeRequest}, 32'h0);
      rw(1'b0, 8'h44, 16'h0);
      chk("cleared flag", rd, exp_csr(1'b0, 1'b1, 2'h0));
      auxReset = 1'b1;
      @(negedge core_clk);
      auxReset = 1'b0;
      rw(1'b0, 8'h44, 16'h0);
      chk("aux reset", rd, exp_csr(1'b0, 1'b0, 2'h0));
      end_sim();
   end
endmodule : testbench
`default_nettype wire
